// >>> mio_pkg.sv
package mio_pkg;
	localparam int BIT_W = 8;
	localparam int NIB_W = 4;
	localparam int SER_W = 3;
	localparam int IRQ_W = 2;
	localparam int ANA_W = 4;
	localparam int PIN_W = 25;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;

	// Bit positions of each port inside the joined pad vector.
	localparam int POS_BIT = 0;
	localparam int POS_NIB_A = 8;
	localparam int POS_NIB_B = 12;
	localparam int POS_SER = 16;
	localparam int POS_IRQ = 19;
	localparam int POS_ANA = 21;

	// Pin numbers inside the bit port that double as timer pins.
	localparam int TMR_A_BIT = 6;
	localparam int TMR_B_BIT = 7;

	localparam logic [ADDR_W-1:0] OFS_BIT_LATCH = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_BIT_PP = 5'h01;
	localparam logic [ADDR_W-1:0] OFS_NIB_A_LATCH = 5'h02;
	localparam logic [ADDR_W-1:0] OFS_NIB_A_PP = 5'h03;
	localparam logic [ADDR_W-1:0] OFS_NIB_A_PULL = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_NIB_B_LATCH = 5'h05;
	localparam logic [ADDR_W-1:0] OFS_NIB_B_PP = 5'h06;
	localparam logic [ADDR_W-1:0] OFS_NIB_B_PULL = 5'h07;
	localparam logic [ADDR_W-1:0] OFS_WAKE_EN = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_SER_LATCH = 5'h09;
	localparam logic [ADDR_W-1:0] OFS_IRQ_LATCH = 5'h0a;
	localparam logic [ADDR_W-1:0] OFS_ANA_LATCH = 5'h0b;
	localparam logic [ADDR_W-1:0] OFS_TMR_CFG = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_BIT_IN = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_NIB_A_IN = 5'h11;
	localparam logic [ADDR_W-1:0] OFS_NIB_B_IN = 5'h12;
	localparam logic [ADDR_W-1:0] OFS_SER_IN = 5'h13;
	localparam logic [ADDR_W-1:0] OFS_IRQ_IN = 5'h14;
	localparam logic [ADDR_W-1:0] OFS_ANA_IN = 5'h15;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h16;

	// Wake enable fields: nibble port a, nibble port b, irq pin a, irq pin b.
	localparam int WAKE_NIB_A = 0;
	localparam int WAKE_NIB_B = 1;
	localparam int WAKE_IRQ_A = 2;
	localparam int WAKE_IRQ_B = 3;

	// Timer pin configuration fields.
	localparam int TCFG_A_OUT = 0;
	localparam int TCFG_A_SRC = 1;
	localparam int TCFG_B_PWM = 2;

	// Status fields.
	localparam int ST_WAKE = 0;
	localparam int ST_DROP_RUN = 1;
	localparam int ST_RST_PIN = 2;
	localparam int ST_TOGGLE = 3;

	localparam logic [DATA_W-1:0] RST_LATCH = 8'hff;
	localparam logic [DATA_W-1:0] RST_CFG = 8'h00;
endpackage

// >>> mio_pad_if.sv
`timescale 1ns/100ps
interface mio_pad_if #(parameter int W = 25);
	logic [W-1:0] val;
	logic [W-1:0] pp;
	logic [W-1:0] out;
	logic [W-1:0] oe;
	modport ctl (output val, output pp, input out, input oe);
	modport pad (input val, input pp, output out, output oe);
endinterface

// >>> mio_sync.sv
`timescale 1ns/100ps
module mio_sync #(
	parameter int W = 1
) (
	input wire logic clk_i, // system clock
	input wire logic nrst_i, // synchronous reset, active low
	input wire logic [W-1:0] async_i, // levels from outside the clock domain
	output logic [W-1:0] sync_o // levels after two flip-flops
);
	logic [W-1:0] meta_reg;

	// Pins idle high, so both stages reset to one to avoid a false low.
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			meta_reg <= '1;
			sync_o <= '1;
		end else begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
	end
endmodule

// >>> mio_pad.sv
`timescale 1ns/100ps
module mio_pad #(
	parameter int W = 25
) (
	input wire logic clk_i, // system clock
	input wire logic nrst_i, // synchronous reset, active low
	mio_pad_if.pad pads // value and structure in, pin drive out
);
	// Each pin is its own driver; outputs are registered so pins never glitch.
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_pin
			always_ff @(posedge clk_i) begin
				if (!nrst_i) begin
					pads.out[g] <= 1'b0;
					pads.oe[g] <= 1'b0;
				end else if (pads.pp[g]) begin
					pads.out[g] <= pads.val[g];
					pads.oe[g] <= 1'b1;
				end else begin
					pads.out[g] <= 1'b0;
					pads.oe[g] <= ~pads.val[g];
				end
			end
		end
	endgenerate
endmodule

// >>> mio_ports.sv
`timescale 1ns/100ps
// Behaviour
// - Each bit port pin has its own path; push-pull or open-drain per pin.
// - Nibble ports: four pins, selectable structure, pull-up and wake enables.
// - Three-bit port is open-drain, shared with serial clock, output, input.
// - Two-bit port is open-drain, pins double as the two interrupt inputs.
// - Analog port: four open-drain pins, each also one converter input.
// - Timer pin a: event input for timer one, or halved underflow output.
// - Timer pin b: event input for timer three, or timer four waveform.
// - Both interrupt pins feed requests and have switchable key-on wakeup.
// - Reset pin is pulled low for any internal system reset source.
// - Drop detector runs only while its enable pin is high.
// - Interrupt port pins keep their input and output while used.
// - Bit pin six input stays readable while timer pin a drives.
module mio_ports (
	input wire logic clk_i, // system clock, 250 MHz
	input wire logic nrst_i, // synchronous reset, active low
	input wire logic [4:0] addr_i, // register address
	input wire logic [7:0] wdata_i, // register write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [7:0] rdata_o, // read data, cycle after the strobe
	input wire logic [7:0] bit_port_pins_i, // bit port pin levels
	output logic [7:0] bit_port_pins_o, // bit port drive value
	output logic [7:0] bit_port_pins_oe_o, // bit port drive enable
	input wire logic [3:0] nibble_port_a_pins_i, // nibble port a levels
	output logic [3:0] nibble_port_a_pins_o, // nibble port a drive value
	output logic [3:0] nibble_port_a_pins_oe_o, // nibble port a drive enable
	output logic [3:0] nibble_port_a_pullup_o, // nibble port a pull-up on
	input wire logic [3:0] nibble_port_b_pins_i, // nibble port b levels
	output logic [3:0] nibble_port_b_pins_o, // nibble port b drive value
	output logic [3:0] nibble_port_b_pins_oe_o, // nibble port b drive enable
	output logic [3:0] nibble_port_b_pullup_o, // nibble port b pull-up on
	input wire logic [2:0] serial_shared_port_pins_i, // serial port levels
	output logic [2:0] serial_shared_port_pins_o, // serial port drive value
	output logic [2:0] serial_shared_port_pins_oe_o, // serial port drive enable
	input wire logic [1:0] irq_shared_port_pins_i, // irq port levels
	output logic [1:0] irq_shared_port_pins_o, // irq port drive value
	output logic [1:0] irq_shared_port_pins_oe_o, // irq port drive enable
	input wire logic [3:0] analog_shared_port_pins_i, // analog port levels
	output logic [3:0] analog_shared_port_pins_o, // analog port drive value
	output logic [3:0] analog_shared_port_pins_oe_o, // analog port drive enable
	input wire logic reset_pin_i, // reset pin level
	output logic reset_pin_o, // reset pin drive value
	output logic reset_pin_oe_o, // reset pin drive enable
	input wire logic drop_detect_enable_pin_i, // drop detector enable pin
	output logic drop_detect_run_o, // drop detector running
	input wire logic drop_detect_i, // drop detector trip, level
	input wire logic software_reset_instruction_i, // reset instruction, level
	input wire logic watchdog_reset_i, // watchdog reset, level
	input wire logic power_on_reset_i, // power-on reset, level
	output logic ext_reset_o, // reset pin seen low
	input wire logic serial_sel_i, // serial unit owns its pins
	input wire logic serial_clk_drive_i, // serial unit drives its clock
	input wire logic serial_clk_i, // serial clock out
	input wire logic serial_data_i, // serial data out
	output logic serial_clk_o, // serial clock in
	output logic serial_data_o, // serial data in
	output logic ext_irq_pin_a_o, // interrupt input a level
	output logic ext_irq_pin_b_o, // interrupt input b level
	output logic [3:0] analog_input_pins_o, // analog pins, digital view
	input wire logic timer1_underflow_i, // timer one underflow pulse
	input wire logic timer2_underflow_i, // timer two underflow pulse
	input wire logic timer4_pwm_i, // timer four waveform
	output logic timer_pin_a_event_o, // timer one event clock
	output logic timer_pin_b_event_o, // timer three event clock
	output logic wake_o // key-on wakeup request
);
	localparam int PW = mio_pkg::PIN_W;
	localparam int AW = mio_pkg::ANA_W;

	logic [7:0] bit_latch_reg;
	logic [7:0] bit_pp_reg;
	logic [3:0] nib_a_latch_reg;
	logic [3:0] nib_a_pp_reg;
	logic [3:0] nib_a_pull_reg;
	logic [3:0] nib_b_latch_reg;
	logic [3:0] nib_b_pp_reg;
	logic [3:0] nib_b_pull_reg;
	logic [3:0] wake_en_reg;
	logic [2:0] ser_latch_reg;
	logic [1:0] irq_latch_reg;
	logic [3:0] ana_latch_reg;
	logic [2:0] tmr_cfg_reg;
	logic toggle_reg;
	logic wake_reg;
	logic rst_drive_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [PW+1:0] raw_in;
	logic [PW+1:0] pin_in;
	logic [PW-1:0] pad_val;
	logic [PW-1:0] pad_pp;
	logic [7:0] bit_in;
	logic [3:0] nib_a_in;
	logic [3:0] nib_b_in;
	logic [2:0] ser_in;
	logic [1:0] irq_in;
	logic [3:0] ana_in;
	logic drop_en;
	logic rst_pin_in;
	logic [7:0] bit_val;
	logic [2:0] ser_val;
	logic toggle_src;
	logic wake_next;
	logic [1:0] settle_reg;

	mio_pad_if #(.W(PW)) pads ();

	// Every pin level crosses into the clock domain before use.
	assign raw_in = {reset_pin_i, drop_detect_enable_pin_i, analog_shared_port_pins_i,
		irq_shared_port_pins_i, serial_shared_port_pins_i, nibble_port_b_pins_i,
		nibble_port_a_pins_i, bit_port_pins_i};

	mio_sync #(.W(PW + 2)) u_sync (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.async_i(raw_in),
		.sync_o(pin_in)
	);

	assign bit_in = pin_in[mio_pkg::POS_BIT +: mio_pkg::BIT_W];
	assign nib_a_in = pin_in[mio_pkg::POS_NIB_A +: mio_pkg::NIB_W];
	assign nib_b_in = pin_in[mio_pkg::POS_NIB_B +: mio_pkg::NIB_W];
	assign ser_in = pin_in[mio_pkg::POS_SER +: mio_pkg::SER_W];
	assign irq_in = pin_in[mio_pkg::POS_IRQ +: mio_pkg::IRQ_W];
	assign ana_in = pin_in[mio_pkg::POS_ANA +: mio_pkg::ANA_W];
	assign drop_en = pin_in[PW] & settle_reg[1];
	assign rst_pin_in = pin_in[PW+1];

	// The synchroniser resets high, which suits the idle-high pads but would
	// show the detector enabled for two cycles after reset even with its pin
	// low; the enable is masked until the pin's own level has come through.
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			settle_reg <= 2'h0;
		end else begin
			settle_reg <= {settle_reg[0], 1'b1};
		end
	end

	// Port latches; reset to ones so no open-drain pin pulls low at start.
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			bit_latch_reg <= mio_pkg::RST_LATCH;
			nib_a_latch_reg <= mio_pkg::RST_LATCH[3:0];
			nib_b_latch_reg <= mio_pkg::RST_LATCH[3:0];
			ser_latch_reg <= mio_pkg::RST_LATCH[2:0];
			irq_latch_reg <= mio_pkg::RST_LATCH[1:0];
			ana_latch_reg <= mio_pkg::RST_LATCH[3:0];
		end else if (wr_i) begin
			case (addr_i)
				mio_pkg::OFS_BIT_LATCH: bit_latch_reg <= wdata_i;
				mio_pkg::OFS_NIB_A_LATCH: nib_a_latch_reg <= wdata_i[3:0];
				mio_pkg::OFS_NIB_B_LATCH: nib_b_latch_reg <= wdata_i[3:0];
				mio_pkg::OFS_SER_LATCH: ser_latch_reg <= wdata_i[2:0];
				mio_pkg::OFS_IRQ_LATCH: irq_latch_reg <= wdata_i[1:0];
				mio_pkg::OFS_ANA_LATCH: ana_latch_reg <= wdata_i[3:0];
				default: begin
				end
			endcase
		end
	end

	// Structure, pull-up, wake and timer pin selections.
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			bit_pp_reg <= mio_pkg::RST_CFG;
			nib_a_pp_reg <= mio_pkg::RST_CFG[3:0];
			nib_a_pull_reg <= mio_pkg::RST_CFG[3:0];
			nib_b_pp_reg <= mio_pkg::RST_CFG[3:0];
			nib_b_pull_reg <= mio_pkg::RST_CFG[3:0];
			wake_en_reg <= mio_pkg::RST_CFG[3:0];
			tmr_cfg_reg <= mio_pkg::RST_CFG[2:0];
		end else if (wr_i) begin
			case (addr_i)
				mio_pkg::OFS_BIT_PP: bit_pp_reg <= wdata_i;
				mio_pkg::OFS_NIB_A_PP: nib_a_pp_reg <= wdata_i[3:0];
				mio_pkg::OFS_NIB_A_PULL: nib_a_pull_reg <= wdata_i[3:0];
				mio_pkg::OFS_NIB_B_PP: nib_b_pp_reg <= wdata_i[3:0];
				mio_pkg::OFS_NIB_B_PULL: nib_b_pull_reg <= wdata_i[3:0];
				mio_pkg::OFS_WAKE_EN: wake_en_reg <= wdata_i[3:0];
				mio_pkg::OFS_TMR_CFG: tmr_cfg_reg <= wdata_i[2:0];
				default: begin
				end
			endcase
		end
	end

	assign nibble_port_a_pullup_o = nib_a_pull_reg;
	assign nibble_port_b_pullup_o = nib_b_pull_reg;

	// Halved underflow output: the selected timer's pulse flips the pin.
	assign toggle_src = tmr_cfg_reg[mio_pkg::TCFG_A_SRC] ? timer2_underflow_i
		: timer1_underflow_i;

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			toggle_reg <= 1'b0;
		end else if (toggle_src) begin
			toggle_reg <= ~toggle_reg;
		end
	end

	// Timer outputs replace the latch on pins six and seven when selected.
	always_comb begin
		bit_val = bit_latch_reg;
		if (tmr_cfg_reg[mio_pkg::TCFG_A_OUT]) begin
			bit_val[mio_pkg::TMR_A_BIT] = toggle_reg;
		end
		if (tmr_cfg_reg[mio_pkg::TCFG_B_PWM]) begin
			bit_val[mio_pkg::TMR_B_BIT] = timer4_pwm_i;
		end
	end

	// Serial signals are gated by the latch, which must hold one to let
	// them through; an idle serial clock releases its pin.
	always_comb begin
		ser_val = ser_latch_reg;
		if (serial_sel_i) begin
			ser_val[0] = ser_latch_reg[0] & (~serial_clk_drive_i | serial_clk_i);
			ser_val[1] = ser_latch_reg[1] & serial_data_i;
		end
	end

	// Three fixed open-drain ports carry zeros in the push-pull field.
	assign pad_val = {ana_latch_reg, irq_latch_reg, ser_val, nib_b_latch_reg,
		nib_a_latch_reg, bit_val};
	assign pad_pp = {{AW{1'b0}}, 2'b00, 3'b000, nib_b_pp_reg, nib_a_pp_reg, bit_pp_reg};
	assign pads.val = pad_val;
	assign pads.pp = pad_pp;

	mio_pad #(.W(PW)) u_pad (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.pads(pads.pad)
	);

	assign bit_port_pins_o = pads.out[mio_pkg::POS_BIT +: mio_pkg::BIT_W];
	assign bit_port_pins_oe_o = pads.oe[mio_pkg::POS_BIT +: mio_pkg::BIT_W];
	assign nibble_port_a_pins_o = pads.out[mio_pkg::POS_NIB_A +: mio_pkg::NIB_W];
	assign nibble_port_a_pins_oe_o = pads.oe[mio_pkg::POS_NIB_A +: mio_pkg::NIB_W];
	assign nibble_port_b_pins_o = pads.out[mio_pkg::POS_NIB_B +: mio_pkg::NIB_W];
	assign nibble_port_b_pins_oe_o = pads.oe[mio_pkg::POS_NIB_B +: mio_pkg::NIB_W];
	assign serial_shared_port_pins_o = pads.out[mio_pkg::POS_SER +: mio_pkg::SER_W];
	assign serial_shared_port_pins_oe_o = pads.oe[mio_pkg::POS_SER +: mio_pkg::SER_W];
	assign irq_shared_port_pins_o = pads.out[mio_pkg::POS_IRQ +: mio_pkg::IRQ_W];
	assign irq_shared_port_pins_oe_o = pads.oe[mio_pkg::POS_IRQ +: mio_pkg::IRQ_W];
	assign analog_shared_port_pins_o = pads.out[mio_pkg::POS_ANA +: mio_pkg::ANA_W];
	assign analog_shared_port_pins_oe_o = pads.oe[mio_pkg::POS_ANA +: mio_pkg::ANA_W];

	// Pin levels to the shared peripherals, always live whatever the latches.
	assign serial_clk_o = ser_in[0];
	assign serial_data_o = ser_in[2];
	assign ext_irq_pin_a_o = irq_in[0];
	assign ext_irq_pin_b_o = irq_in[1];
	assign analog_input_pins_o = ana_in;
	assign timer_pin_a_event_o = bit_in[mio_pkg::TMR_A_BIT];
	assign timer_pin_b_event_o = bit_in[mio_pkg::TMR_B_BIT];

	// A low on any enabled key pin asks the clock control to wake.
	always_comb begin
		wake_next = 1'b0;
		if (wake_en_reg[mio_pkg::WAKE_NIB_A] && (nib_a_in != 4'hf)) begin
			wake_next = 1'b1;
		end
		if (wake_en_reg[mio_pkg::WAKE_NIB_B] && (nib_b_in != 4'hf)) begin
			wake_next = 1'b1;
		end
		if (wake_en_reg[mio_pkg::WAKE_IRQ_A] && !irq_in[0]) begin
			wake_next = 1'b1;
		end
		if (wake_en_reg[mio_pkg::WAKE_IRQ_B] && !irq_in[1]) begin
			wake_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wake_reg <= 1'b0;
		end else begin
			wake_reg <= wake_next;
		end
	end

	assign wake_o = wake_reg;

	// Detector follows its enable pin; its trip only counts while it runs.
	assign drop_detect_run_o = drop_en;

	// The reset pin is held low while any internal reset source is active;
	// it is a level, so a source longer than one cycle shows its full length.
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rst_drive_reg <= 1'b0;
		end else begin
			rst_drive_reg <= software_reset_instruction_i | watchdog_reset_i
				| power_on_reset_i | (drop_detect_i & drop_en);
		end
	end

	assign reset_pin_o = 1'b0;
	assign reset_pin_oe_o = rst_drive_reg;
	assign ext_reset_o = ~rst_pin_in;

	// Read mux; unmapped addresses read as zero.
	always_comb begin
		rdata_next = 8'h00;
		case (addr_i)
			mio_pkg::OFS_BIT_LATCH: rdata_next = bit_latch_reg;
			mio_pkg::OFS_BIT_PP: rdata_next = bit_pp_reg;
			mio_pkg::OFS_NIB_A_LATCH: rdata_next = {4'h0, nib_a_latch_reg};
			mio_pkg::OFS_NIB_A_PP: rdata_next = {4'h0, nib_a_pp_reg};
			mio_pkg::OFS_NIB_A_PULL: rdata_next = {4'h0, nib_a_pull_reg};
			mio_pkg::OFS_NIB_B_LATCH: rdata_next = {4'h0, nib_b_latch_reg};
			mio_pkg::OFS_NIB_B_PP: rdata_next = {4'h0, nib_b_pp_reg};
			mio_pkg::OFS_NIB_B_PULL: rdata_next = {4'h0, nib_b_pull_reg};
			mio_pkg::OFS_WAKE_EN: rdata_next = {4'h0, wake_en_reg};
			mio_pkg::OFS_SER_LATCH: rdata_next = {5'h00, ser_latch_reg};
			mio_pkg::OFS_IRQ_LATCH: rdata_next = {6'h00, irq_latch_reg};
			mio_pkg::OFS_ANA_LATCH: rdata_next = {4'h0, ana_latch_reg};
			mio_pkg::OFS_TMR_CFG: rdata_next = {5'h00, tmr_cfg_reg};
			mio_pkg::OFS_BIT_IN: rdata_next = bit_in;
			mio_pkg::OFS_NIB_A_IN: rdata_next = {4'h0, nib_a_in};
			mio_pkg::OFS_NIB_B_IN: rdata_next = {4'h0, nib_b_in};
			mio_pkg::OFS_SER_IN: rdata_next = {5'h00, ser_in};
			mio_pkg::OFS_IRQ_IN: rdata_next = {6'h00, irq_in};
			mio_pkg::OFS_ANA_IN: rdata_next = {4'h0, ana_in};
			mio_pkg::OFS_STATUS: rdata_next = {4'h0, toggle_reg, rst_pin_in, drop_en, wake_reg};
			default: rdata_next = 8'h00;
		endcase
	end

	// Read data stand for one cycle only and are zero otherwise.
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rdata_reg <= 8'h00;
		end else if (rd_i) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	assign rdata_o = rdata_reg;
endmodule

// >>> mio_ports_monitor.sv
`timescale 1ns/100ps
module mio_ports_monitor (
	input wire logic clk_i, // clock
	input wire logic nrst_i, // reset
	input wire logic [7:0] bit_port_pins_i, // pad
	input wire logic [7:0] bit_port_pins_o, // drive
	input wire logic [7:0] bit_port_pins_oe_o, // enable
	input wire logic [3:0] nibble_port_a_pins_o, // drive
	input wire logic [3:0] nibble_port_a_pins_oe_o, // enable
	input wire logic [2:0] serial_shared_port_pins_o, // drive
	input wire logic [1:0] irq_shared_port_pins_i, // pad
	input wire logic [1:0] irq_shared_port_pins_o, // drive
	input wire logic [3:0] analog_shared_port_pins_i, // pad
	input wire logic [3:0] analog_shared_port_pins_o, // drive
	input wire logic [3:0] analog_input_pins_o, // converter view
	input wire logic ext_irq_pin_a_o, // irq a
	input wire logic ext_irq_pin_b_o, // irq b
	input wire logic timer_pin_a_event_o, // event a
	input wire logic timer_pin_b_event_o, // event b
	input wire logic drop_detect_enable_pin_i, // enable pin
	input wire logic drop_detect_run_o, // detector on
	input wire logic drop_detect_i, // trip
	input wire logic software_reset_instruction_i, // source
	input wire logic watchdog_reset_i, // source
	input wire logic power_on_reset_i, // source
	input wire logic reset_pin_o, // drive
	input wire logic reset_pin_oe_o // enable
);
	// Synchronisers reset to ones, so pad relations wait three clean cycles.
	logic [1:0] up_q;
	always_ff @(posedge clk_i) begin
		if (!nrst_i) up_q <= 2'h0;
		else if (up_q != 2'h3) up_q <= up_q + 2'h1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	AST_PP_DRIVE: assert property ((bit_port_pins_o & ~bit_port_pins_oe_o) == 8'h00
		&& (nibble_port_a_pins_o & ~nibble_port_a_pins_oe_o) == 4'h0)
		else $error("pad drives high without enable");
	AST_OD_FIXED: assert property ({serial_shared_port_pins_o, irq_shared_port_pins_o,
		analog_shared_port_pins_o} == 9'h000) else $error("open-drain pad drives high");
	AST_IRQ_SYNC: assert property (up_q == 2'h3 |->
		{ext_irq_pin_b_o, ext_irq_pin_a_o} == $past(irq_shared_port_pins_i, 2))
		else $error("interrupt input level wrong");
	AST_ANA_SYNC: assert property (up_q == 2'h3 |->
		analog_input_pins_o == $past(analog_shared_port_pins_i, 2)) else $error("analog view wrong");
	AST_TMR_A: assert property (up_q == 2'h3 |->
		timer_pin_a_event_o == $past(bit_port_pins_i[6], 2)) else $error("event a wrong");
	AST_TMR_B: assert property (up_q == 2'h3 |->
		timer_pin_b_event_o == $past(bit_port_pins_i[7], 2)) else $error("event b wrong");
	AST_DROP_RUN: assert property (up_q == 2'h3 |->
		drop_detect_run_o == $past(drop_detect_enable_pin_i, 2)) else $error("detector run wrong");
	AST_RST_SRC: assert property ((software_reset_instruction_i || watchdog_reset_i
		|| power_on_reset_i) |=> reset_pin_oe_o && !reset_pin_o) else $error("reset pin not low");
	AST_RST_DROP: assert property (!(software_reset_instruction_i || watchdog_reset_i
		|| power_on_reset_i) |=> reset_pin_oe_o == $past(drop_detect_i && drop_detect_run_o))
		else $error("reset pin drive wrong");
	AST_RESET_STATE: assert property ($rose(nrst_i) |-> bit_port_pins_oe_o == 8'h00
		&& nibble_port_a_pins_oe_o == 4'h0 && !reset_pin_oe_o) else $error("pads not released");
endmodule
bind mio_ports mio_ports_monitor i_mon (.*);

// >>> mio_board.sv
`timescale 1ns/100ps
module mio_board (
	input wire logic [24:0] drv_i, // pad drive values
	input wire logic [24:0] oe_i, // pad drive enables
	input wire logic [24:0] key_i, // key pressed, grounds the pad
	input wire logic rst_oe_i, // reset pin pulled low
	output logic [24:0] lvl_o, // resolved pad levels
	output logic rst_lvl_o // reset pin level
);
	// Every pad has a board pull-up; a key only wins while the chip releases the pad.
	assign lvl_o = (oe_i & drv_i) | (~oe_i & ~key_i);
	assign rst_lvl_o = !rst_oe_i;
endmodule

// >>> mio_ports_test.sv
`timescale 1ns/100ps
module mio_ports_test;
	logic clk_i, nrst_i, wr_i, rd_i;
	logic [4:0] addr_i;
	logic [7:0] wdata_i, rdata_o, bit_port_pins_i, bit_port_pins_o, bit_port_pins_oe_o;
	logic [3:0] nibble_port_a_pins_i, nibble_port_a_pins_o, nibble_port_a_pins_oe_o;
	logic [3:0] nibble_port_a_pullup_o, nibble_port_b_pins_i, nibble_port_b_pins_o;
	logic [3:0] nibble_port_b_pins_oe_o, nibble_port_b_pullup_o, analog_shared_port_pins_i;
	logic [3:0] analog_shared_port_pins_o, analog_shared_port_pins_oe_o, analog_input_pins_o;
	logic [2:0] serial_shared_port_pins_i, serial_shared_port_pins_o;
	logic [2:0] serial_shared_port_pins_oe_o;
	logic [1:0] irq_shared_port_pins_i, irq_shared_port_pins_o, irq_shared_port_pins_oe_o;
	logic reset_pin_i, reset_pin_o, reset_pin_oe_o, drop_detect_enable_pin_i, drop_detect_run_o;
	logic drop_detect_i, software_reset_instruction_i, watchdog_reset_i, power_on_reset_i;
	logic ext_reset_o, serial_sel_i, serial_clk_drive_i, serial_clk_i, serial_data_i;
	logic serial_clk_o, serial_data_o, ext_irq_pin_a_o, ext_irq_pin_b_o, timer1_underflow_i;
	logic timer2_underflow_i, timer4_pwm_i, timer_pin_a_event_o, timer_pin_b_event_o, wake_o;
	logic [24:0] drv, oe, key, lvl;
	logic [31:0] seed;
	int fail_count = 0;
	int n_compared = 0;
	int cyc = 0;
	// Address 1f is unmapped; it stands in for ports that have no structure register.
	logic [4:0] ra [15] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
		5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h16, 5'h1f};
	logic [7:0] rv [15] = '{8'hff, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00,
		8'h07, 8'h03, 8'h0f, 8'h00, 8'h04, 8'h00};
	int pos [6] = '{0, 8, 12, 16, 19, 21};
	int wid [6] = '{8, 4, 4, 3, 2, 4};
	logic [4:0] lat [6] = '{5'h00, 5'h02, 5'h05, 5'h09, 5'h0a, 5'h0b};
	logic [4:0] ppo [6] = '{5'h01, 5'h03, 5'h06, 5'h1f, 5'h1f, 5'h1f};
	int wp [4] = '{8, 12, 19, 20};
	assign drv = {analog_shared_port_pins_o, irq_shared_port_pins_o, serial_shared_port_pins_o,
		nibble_port_b_pins_o, nibble_port_a_pins_o, bit_port_pins_o};
	assign oe = {analog_shared_port_pins_oe_o, irq_shared_port_pins_oe_o,
		serial_shared_port_pins_oe_o, nibble_port_b_pins_oe_o, nibble_port_a_pins_oe_o,
		bit_port_pins_oe_o};
	assign {analog_shared_port_pins_i, irq_shared_port_pins_i, serial_shared_port_pins_i,
		nibble_port_b_pins_i, nibble_port_a_pins_i, bit_port_pins_i} = lvl;
	mio_ports i_dut (.*);
	mio_board i_board (.drv_i(drv), .oe_i(oe), .key_i(key), .rst_oe_i(reset_pin_oe_o),
		.lvl_o(lvl), .rst_lvl_o(reset_pin_i));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [7:0] fld(logic [24:0] v, int p, int w);
		return 8'((v >> p) & ((25'h1 << w) - 25'h1));
	endfunction
	task automatic wrap_up();
		if (fail_count == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			wrap_up();
		end
	end
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		n_compared++;
		if (e !== g) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Every task leaves the bench 1 ns after an edge, so outputs have settled.
	task automatic tick(int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(logic [4:0] a, logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	task automatic rdc(logic [4:0] a, logic [7:0] e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk("rdata", e, rdata_o);
	endtask
	task automatic do_reset();
		nrst_i <= 1'b0;
		tick(12);
		nrst_i <= 1'b1;
		tick(1);
	endtask
	initial begin
		logic [7:0] d, l, p, m;
		logic t;
		seed = 32'h4f;
		{nrst_i, wr_i, rd_i, addr_i, wdata_i, key, serial_sel_i, serial_clk_drive_i, serial_clk_i,
			serial_data_i, timer1_underflow_i, timer2_underflow_i, timer4_pwm_i, drop_detect_i,
			software_reset_instruction_i, watchdog_reset_i, power_on_reset_i,
			drop_detect_enable_pin_i} = '0;
		do_reset();
		wr(5'h1f, 8'h5a);
		foreach (ra[i]) rdc(ra[i], rv[i]);
		for (int k = 0; k < 6; k++) begin
			m = 8'((9'h1 << wid[k]) - 9'h1);
			repeat (4) begin
				l = 8'(rnd());
				p = (ppo[k] == 5'h1f) ? 8'h00 : 8'(rnd());
				key <= 25'(rnd());
				wr(lat[k], l);
				wr(ppo[k], p);
				tick(3);
				chk("oe", (p | ~l) & m, fld(oe, pos[k], wid[k]));
				chk("drive", p & l & m, fld(drv, pos[k], wid[k]));
				rdc(5'h10 + 5'(k), l & (p | ~fld(key, pos[k], wid[k])) & m);
			end
			if (k == 1 || k == 2) begin
				d = 8'(rnd());
				wr(k == 1 ? 5'h04 : 5'h07, d);
				tick(2);
				chk("pull", d & 8'h0f, 8'(k == 1 ? nibble_port_a_pullup_o : nibble_port_b_pullup_o));
			end
		end
		key <= '0;
		for (int k = 0; k < 6; k++) begin
			wr(lat[k], 8'hff);
			wr(ppo[k], 8'h00);
		end
		for (int j = 0; j < 4; j++) begin
			wr(5'h08, 8'h01 << j);
			for (int g = 0; g < 4; g++) begin
				key <= 25'h1 << wp[g];
				tick(5);
				chk("wake", 8'(g == j), {7'h0, wake_o});
			end
		end
		key <= '0;
		wr(5'h01, 8'hc0);
		t = 1'b0;
		for (int s = 0; s < 2; s++) begin
			wr(5'h0c, s ? 8'h07 : 8'h05);
			repeat (6) begin
				d = 8'(rnd());
				timer1_underflow_i <= d[0];
				timer2_underflow_i <= d[1];
				timer4_pwm_i <= d[2];
				tick(1);
				timer1_underflow_i <= 1'b0;
				timer2_underflow_i <= 1'b0;
				if (s ? d[1] : d[0]) t = !t;
				tick(4);
				chk("toggle", {7'h0, t}, {7'h0, bit_port_pins_o[6]});
				chk("pwm", {7'h0, d[2]}, {7'h0, bit_port_pins_o[7]});
				rdc(5'h10, {d[2], t, 6'h3f});
			end
		end
		serial_sel_i <= 1'b1;
		repeat (6) begin
			d = 8'(rnd());
			serial_clk_i <= d[0];
			serial_data_i <= d[1];
			serial_clk_drive_i <= d[2];
			key <= 25'(d[3]) << 18;
			tick(4);
			chk("ser_in", {6'h0, ~d[3], ~d[2] | d[0]},
				{6'h0, serial_data_o, serial_clk_o});
			chk("serial", {6'h0, ~d[1], d[2] & ~d[0]}, {6'h0, serial_shared_port_pins_oe_o[1:0]});
		end
		for (int s = 0; s < 5; s++) begin
			drop_detect_enable_pin_i <= (s != 4);
			tick(3);
			d = 8'h01 << (s == 4 ? 3 : s);
			{drop_detect_i, power_on_reset_i, watchdog_reset_i, software_reset_instruction_i} <= d[3:0];
			tick(5);
			chk("run", 8'(s != 4), {7'h0, drop_detect_run_o});
			chk("rst_oe", 8'(s != 4), {7'h0, reset_pin_oe_o});
			chk("ext_rst", 8'(s != 4), {7'h0, ext_reset_o});
			{drop_detect_i, power_on_reset_i, watchdog_reset_i, software_reset_instruction_i} <= 4'h0;
			tick(5);
			chk("rst_off", 8'h00, {7'h0, reset_pin_oe_o});
		end
		wr(5'h00, 8'h00);
		do_reset();
		chk("oe_rst", 8'h00, oe[7:0]);
		rdc(5'h00, 8'hff);
		wrap_up();
	end
endmodule
